// [src/kbi_pkg.sv]
package kbi_pkg;

	// ==========================================================
	// widths
	localparam int NUM_PINS = 8;
	localparam int REG_W = 8;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int EV_W = 3;

	// ==========================================================
	// register byte addresses on the bus
	localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PIN_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_EDGE_SELECT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_PIN_STATE = 8'h14;

	// ==========================================================
	// status and control field positions
	localparam int BIT_FLAG = 3;
	localparam int BIT_ACK = 2;
	localparam int BIT_IE = 1;
	localparam int BIT_MODE = 0;

	// ==========================================================
	// event status field positions
	localparam int EV_EDGE = 0;
	localparam int EV_FLAG_SET = 1;
	localparam int EV_ACK_HELD = 2;

	// ==========================================================
	// values after reset
	localparam logic [REG_W-1:0] RST_PIN_ENABLE = 8'h00;
	localparam logic [REG_W-1:0] RST_EDGE_SELECT = 8'h00;
	localparam logic [EV_W-1:0] RST_IRQ_STATUS = 3'h0;
	localparam logic [EV_W-1:0] RST_IRQ_MASK = 3'h0;
	localparam logic [NUM_PINS-1:0] RST_SYNC = 8'h00;

	// ==========================================================
	// arming state of the edge detector
	typedef enum logic [1:0]
	{
		DET_IDLE = 2'b01,
		DET_ARMED = 2'b10
	} det_state_t;

endpackage

// [src/pin_sync.sv]
`timescale 1ns/100ps

// two flip-flop synchroniser, one chain per pin
module pin_sync
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pin_async,
	output logic [kbi_pkg::NUM_PINS-1:0] pin_sync_out
);
	import kbi_pkg::*;

	logic [NUM_PINS-1:0] stage1_r;
	logic [NUM_PINS-1:0] stage2_r;

	genvar i;
	generate
		for (i = 0; i < NUM_PINS; i++)
		begin : g_chain
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					stage1_r[i] <= RST_SYNC[i];
					stage2_r[i] <= RST_SYNC[i];
				end
				else
				begin
					stage1_r[i] <= pin_async[i];
					stage2_r[i] <= stage1_r[i];
				end
			end
		end
	endgenerate

	assign pin_sync_out = stage2_r;

endmodule // pin_sync

// [src/key_detect.sv]
`timescale 1ns/100ps

// edge and level detection over the synchronised pins
module key_detect
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold_clear,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pin_level,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pin_source_enable,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pin_polarity_select,
	output logic edge_hit,
	output logic any_asserted,
	output logic all_deasserted
);
	import kbi_pkg::*;

	det_state_t state_r;
	det_state_t state_nxt;
	logic [NUM_PINS-1:0] prev_r;
	logic [NUM_PINS-1:0] asserted_now;
	logic [NUM_PINS-1:0] asserted_prev;

	// polarity 0: low is asserted; polarity 1: high is asserted
	assign asserted_now = pin_source_enable & ~(pin_level ^ pin_polarity_select);
	assign asserted_prev = pin_source_enable & ~(prev_r ^ pin_polarity_select);
	assign any_asserted = |asserted_now;
	assign all_deasserted = ~any_asserted;

	// deasserted on one cycle, asserted on the next
	assign edge_hit = (state_r == DET_ARMED) && (|(asserted_now & ~asserted_prev));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_r <= RST_SYNC;
		else
			prev_r <= pin_level;
	end

	// rearm only once every enabled pin is back at rest
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			DET_IDLE:
				if (all_deasserted)
					state_nxt = DET_ARMED;
			DET_ARMED:
				// any enabled pin asserted, by an edge or by a new enable or polarity, disarms
				if (!all_deasserted)
					state_nxt = DET_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= DET_IDLE;
		else if (hold_clear)
			state_r <= DET_IDLE;
		else
			state_r <= state_nxt;
	end

endmodule // key_detect

// [src/keyboard_pin_interrupt.sv]
`timescale 1ns/100ps

module keyboard_pin_interrupt
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [kbi_pkg::ADDR_W-1:0] paddr,
	input wire logic [kbi_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [kbi_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [kbi_pkg::NUM_PINS-1:0] keypad_input_pin,
	input wire logic [kbi_pkg::NUM_PINS-1:0] port_resistor_enable,
	output logic [kbi_pkg::NUM_PINS-1:0] pull_up_select,
	output logic [kbi_pkg::NUM_PINS-1:0] pull_down_select,
	input wire logic stop_deep,
	input wire logic stop_shallow,
	output logic key_irq_request,
	output logic wake_request,
	output logic irq
);
	import kbi_pkg::*;

	// ==========================================================
	// declarations
	logic key_event_flag_r;
	logic key_event_flag_nxt;
	logic key_irq_enable_r;
	logic detect_mode_select_r;
	logic [NUM_PINS-1:0] pin_source_enable_r;
	logic [NUM_PINS-1:0] pin_polarity_select_r;
	logic [EV_W-1:0] irq_status_r;
	logic [EV_W-1:0] irq_status_nxt;
	logic [EV_W-1:0] irq_mask_r;
	logic [EV_W-1:0] events;

	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] rd_mux;
	logic pslverr_r;
	logic addr_hit;
	logic setup_phase;
	logic access_phase;
	logic wr_done;
	logic rd_done;

	logic wr_status_control;
	logic wr_pin_enable;
	logic wr_edge_select;
	logic wr_irq_mask;
	logic rd_irq_status;

	logic ack_write;
	logic ack_ok;
	logic flag_set;
	logic [NUM_PINS-1:0] pin_level;
	logic [NUM_PINS-1:0] raw_asserted;
	logic edge_hit;
	logic any_asserted;
	logic all_deasserted;

	// ==========================================================
	// pin synchroniser and detector
	pin_sync u_pin_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(keypad_input_pin),
		.pin_sync_out(pin_level)
	);

	// deep stop drops the arming too, so a wake-up starts unarmed
	key_detect u_key_detect
	(
		.pclk(pclk),
		.presetn(presetn),
		.hold_clear(stop_deep),
		.pin_level(pin_level),
		.pin_source_enable(pin_source_enable_r),
		.pin_polarity_select(pin_polarity_select_r),
		.edge_hit(edge_hit),
		.any_asserted(any_asserted),
		.all_deasserted(all_deasserted)
	);

	// ==========================================================
	// apb decode
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_done = access_phase && pwrite && pstrb[0];
	assign rd_done = access_phase && !pwrite;

	always_comb
	begin
		addr_hit = 1'h0;
		case (paddr)
			OFF_STATUS_CONTROL,
			OFF_PIN_ENABLE,
			OFF_EDGE_SELECT,
			OFF_IRQ_STATUS,
			OFF_IRQ_MASK,
			OFF_PIN_STATE:
				addr_hit = 1'h1;
			default:
				addr_hit = 1'h0;
		endcase
	end

	// one write strobe per writable register and a read strobe for irq status; pin state and unmapped addresses raise none
	always_comb
	begin
		wr_status_control = 1'h0;
		wr_pin_enable = 1'h0;
		wr_edge_select = 1'h0;
		wr_irq_mask = 1'h0;
		rd_irq_status = 1'h0;
		case (paddr)
			OFF_STATUS_CONTROL:
				wr_status_control = wr_done;
			OFF_PIN_ENABLE:
				wr_pin_enable = wr_done;
			OFF_EDGE_SELECT:
				wr_edge_select = wr_done;
			OFF_IRQ_MASK:
				wr_irq_mask = wr_done;
			OFF_IRQ_STATUS:
				rd_irq_status = rd_done;
			default:
				rd_irq_status = 1'h0;
		endcase
	end

	// zero wait states: the access phase always completes
	assign pready = access_phase;
	assign pslverr = access_phase && pslverr_r;
	assign prdata = prdata_r;

	// ==========================================================
	// read mux, sampled in the setup cycle
	always_comb
	begin
		rd_mux = '0;
		case (paddr)
			OFF_STATUS_CONTROL:
			begin
				rd_mux[REG_W-1:BIT_FLAG+1] = '0;
				rd_mux[BIT_FLAG] = key_event_flag_r;
				rd_mux[BIT_ACK] = 1'h0;
				rd_mux[BIT_IE] = key_irq_enable_r;
				rd_mux[BIT_MODE] = detect_mode_select_r;
			end
			OFF_PIN_ENABLE:
				rd_mux[NUM_PINS-1:0] = pin_source_enable_r;
			OFF_EDGE_SELECT:
				rd_mux[NUM_PINS-1:0] = pin_polarity_select_r;
			OFF_IRQ_STATUS:
				rd_mux[EV_W-1:0] = irq_status_r;
			OFF_IRQ_MASK:
				rd_mux[EV_W-1:0] = irq_mask_r;
			OFF_PIN_STATE:
				rd_mux[NUM_PINS-1:0] = pin_level;
			default:
				rd_mux = '0;
		endcase
	end
	// bits 31:8 of status and control stay zero from the default above

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= '0;
		else if (setup_phase)
			prdata_r <= pwrite ? '0 : rd_mux;
	end

	// the decode error stands from setup through the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_r <= 1'h0;
		else if (setup_phase)
			pslverr_r <= !addr_hit;
	end

	// ==========================================================
	// control bits; deep stop returns them to reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			key_irq_enable_r <= 1'h0;
		else if (stop_deep)
			key_irq_enable_r <= 1'h0;
		else if (wr_status_control)
			key_irq_enable_r <= pwdata[BIT_IE];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			detect_mode_select_r <= 1'h0;
		else if (stop_deep)
			detect_mode_select_r <= 1'h0;
		else if (wr_status_control)
			detect_mode_select_r <= pwdata[BIT_MODE];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_source_enable_r <= RST_PIN_ENABLE;
		else if (stop_deep)
			pin_source_enable_r <= RST_PIN_ENABLE;
		else if (wr_pin_enable)
			pin_source_enable_r <= pwdata[NUM_PINS-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_polarity_select_r <= RST_EDGE_SELECT;
		else if (stop_deep)
			pin_polarity_select_r <= RST_EDGE_SELECT;
		else if (wr_edge_select)
			pin_polarity_select_r <= pwdata[NUM_PINS-1:0];
	end

	// ==========================================================
	// shared flag
	assign ack_write = wr_status_control && pwdata[BIT_ACK];
	// level mode holds the flag while any enabled pin is asserted
	assign ack_ok = ack_write && (!detect_mode_select_r || all_deasserted);
	// every enabled pin of the eight merges into the one flag
	assign flag_set = edge_hit || (detect_mode_select_r && any_asserted);

	always_comb
	begin
		key_event_flag_nxt = key_event_flag_r;
		if (flag_set)
			key_event_flag_nxt = 1'h1;
		else if (ack_ok)
			key_event_flag_nxt = 1'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			key_event_flag_r <= 1'h0;
		else if (stop_deep)
			key_event_flag_r <= 1'h0;
		else
			key_event_flag_r <= key_event_flag_nxt;
	end

	// wait mode needs nothing special: the clock keeps running
	assign key_irq_request = key_event_flag_r && key_irq_enable_r;

	// ==========================================================
	// per-pin pad resistor direction and raw assertion
	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++)
		begin : g_pin
			// a pin without its resistor gets neither direction
			assign pull_up_select[p] = port_resistor_enable[p]
				&& !pin_polarity_select_r[p];
			assign pull_down_select[p] = port_resistor_enable[p]
				&& pin_polarity_select_r[p];
			// unsynchronised on purpose: pclk may stand still in stop3
			assign raw_asserted[p] = pin_source_enable_r[p]
				&& (keypad_input_pin[p] == pin_polarity_select_r[p]);
		end
	endgenerate

	// ==========================================================
	// stop3 wake request
	assign wake_request = stop_shallow && key_irq_enable_r && (|raw_asserted);

	// ==========================================================
	// sticky events, cleared by reading, set wins over clear
	always_comb
	begin
		events = '0;
		events[EV_EDGE] = edge_hit;
		events[EV_FLAG_SET] = !key_event_flag_r && key_event_flag_nxt;
		events[EV_ACK_HELD] = ack_write && !ack_ok;
	end

	// a read clears only the bits that it returned
	genvar b;
	generate
		for (b = 0; b < EV_W; b++)
		begin : g_event
			assign irq_status_nxt[b] = events[b]
				|| (irq_status_r[b] && !(rd_irq_status && prdata_r[b]));
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status_r <= RST_IRQ_STATUS;
		else if (stop_deep)
			irq_status_r <= RST_IRQ_STATUS;
		else
			irq_status_r <= irq_status_nxt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_r <= RST_IRQ_MASK;
		else if (stop_deep)
			irq_mask_r <= RST_IRQ_MASK;
		else if (wr_irq_mask)
			irq_mask_r <= pwdata[EV_W-1:0];
	end

	assign irq = |(irq_status_r & irq_mask_r);

endmodule // keyboard_pin_interrupt

// [sim/kbi_props.sv]
`timescale 1ns/100ps

// ==========
// port checks
module kbi_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [kbi_pkg::ADDR_W-1:0] paddr,
	input wire logic [kbi_pkg::DATA_W-1:0] prdata,
	input wire logic pslverr,
	input wire logic [kbi_pkg::NUM_PINS-1:0] port_resistor_enable,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pull_up_select,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pull_down_select,
	input wire logic stop_deep,
	input wire logic stop_shallow,
	input wire logic key_irq_request,
	input wire logic wake_request,
	input wire logic irq
);
	import kbi_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic sc_rd;
	assign sc_rd = psel & penable & !pwrite & (paddr == OFF_STATUS_CONTROL);
	property p_hi_zero;
		sc_rd |-> prdata[7:4] == 4'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits not zero");
	property p_ack_zero;
		sc_rd |-> !prdata[BIT_ACK];
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("ack bit reads one");
	property p_req_gate;
		sc_rd |-> $past(key_irq_request) == (prdata[BIT_FLAG] & prdata[BIT_IE]);
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("request not flag and enable");
	property p_pull_excl;
		(pull_up_select & pull_down_select) == 8'h00;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("pullup and pulldown together");
	property p_pull_follow;
		(pull_up_select | pull_down_select) == port_resistor_enable;
	endproperty
	a_pull_follow: assert property (p_pull_follow) else $error("resistor without enable");
	property p_stop_clear;
		stop_deep |=> !key_irq_request && !irq && !wake_request;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("deep stop left state");
	property p_wake_off;
		!stop_shallow |-> !wake_request;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake outside stop");
	property p_unmapped;
		psel && penable && paddr > OFF_PIN_STATE |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	c_req: cover property ($rose(key_irq_request));
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wake_request));
endmodule // kbi_props

bind keyboard_pin_interrupt kbi_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.port_resistor_enable(port_resistor_enable), .pull_up_select(pull_up_select),
	.pull_down_select(pull_down_select), .stop_deep(stop_deep), .stop_shallow(stop_shallow),
	.key_irq_request(key_irq_request), .wake_request(wake_request), .irq(irq));

// [sim/key_switch_model.sv]
`timescale 1ns/100ps

// ==========
// switches: a pressed key drives against its resistor
module key_switch_model
(
	input wire logic pclk,
	input wire logic [kbi_pkg::NUM_PINS-1:0] press,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pull_up_select,
	input wire logic [kbi_pkg::NUM_PINS-1:0] pull_down_select,
	output logic [kbi_pkg::NUM_PINS-1:0] pin
);
	import kbi_pkg::*;
	logic [NUM_PINS-1:0] float_r = 8'h00;
	always_ff @(posedge pclk)
	begin
		float_r <= ~float_r;
	end
	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
		begin
			if (pull_up_select[i])
				pin[i] = ~press[i];
			else if (pull_down_select[i])
				pin[i] = press[i];
			else
				pin[i] = float_r[i];
		end
	end
endmodule // key_switch_model

// [sim/keyboard_pin_interrupt_tb.sv]
`timescale 1ns/100ps

// ==========
// bench
module keyboard_pin_interrupt_tb;
	import kbi_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_PINS-1:0] pins;
	logic [NUM_PINS-1:0] press = 8'h00;
	logic [NUM_PINS-1:0] res_en = 8'hFF;
	logic [NUM_PINS-1:0] pu;
	logic [NUM_PINS-1:0] pd;
	logic stop_deep = 1'b0;
	logic stop_shallow = 1'b0;
	logic kirq;
	logic wake;
	logic irq;
	int err_total = 0;
	int n_tests = 0;
	always #5 pclk = ~pclk;
	keyboard_pin_interrupt dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .keypad_input_pin(pins),
		.port_resistor_enable(res_en), .pull_up_select(pu), .pull_down_select(pd),
		.stop_deep(stop_deep), .stop_shallow(stop_shallow), .key_irq_request(kirq),
		.wake_request(wake), .irq(irq));
	key_switch_model sw_u (.pclk(pclk), .press(press), .pull_up_select(pu),
		.pull_down_select(pd), .pin(pins));
	// ==========
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic arm(input logic [7:0] edg, input logic [7:0] en);
		wr(OFF_STATUS_CONTROL, 32'h0);
		wr(OFF_EDGE_SELECT, {24'h0, edg});
		wr(OFF_PIN_ENABLE, {24'h0, en});
		wr(OFF_STATUS_CONTROL, 32'h4);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========
	// tests
	initial
	begin
		logic [31:0] q;
		logic e;
		cyc(5);
		presetn <= 1'b1;
		cyc(1);
		rd(OFF_STATUS_CONTROL, 32'h0);
		rd(OFF_PIN_ENABLE, 32'h0);
		rd(OFF_EDGE_SELECT, 32'h0);
		rd(OFF_PIN_STATE, 32'hFF);
		xfer(1'b0, 8'h40, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		wr(OFF_PIN_ENABLE, 32'hA5);
		rd(OFF_PIN_ENABLE, 32'hA5);
		wr(OFF_EDGE_SELECT, 32'h5A);
		rd(OFF_EDGE_SELECT, 32'h5A);
		chk({pu, pd}, 32'hA55A);
		wr(OFF_STATUS_CONTROL, 32'hFF);
		rd(OFF_STATUS_CONTROL, 32'h03);
		arm(8'h00, 8'h01);
		wr(OFF_STATUS_CONTROL, 32'h2);
		press <= 8'h01;
		cyc(6);
		chk(kirq, 1'b1);
		rd(OFF_STATUS_CONTROL, 32'h0A);
		wr(OFF_STATUS_CONTROL, 32'h6);
		rd(OFF_STATUS_CONTROL, 32'h02);
		chk(kirq, 1'b0);
		press <= 8'h00;
		cyc(4);
		arm(8'hC0, 8'hC0);
		press <= 8'h80;
		cyc(6);
		rd(OFF_STATUS_CONTROL, 32'h08);
		wr(OFF_STATUS_CONTROL, 32'h4);
		press <= 8'hC0;
		cyc(6);
		rd(OFF_STATUS_CONTROL, 32'h00);
		press <= 8'h00;
		cyc(4);
		press <= 8'h40;
		cyc(6);
		rd(OFF_STATUS_CONTROL, 32'h08);
		press <= 8'h00;
		cyc(4);
		wr(OFF_STATUS_CONTROL, 32'h4);
		press <= 8'h01;
		cyc(6);
		rd(OFF_STATUS_CONTROL, 32'h00);
		press <= 8'h00;
		arm(8'h00, 8'h01);
		wr(OFF_IRQ_MASK, 32'h0);
		xfer(1'b0, OFF_IRQ_STATUS, 32'h0, q, e);
		wr(OFF_STATUS_CONTROL, 32'h3);
		press <= 8'h01;
		cyc(6);
		wr(OFF_STATUS_CONTROL, 32'h7);
		rd(OFF_STATUS_CONTROL, 32'h0B);
		chk(irq, 1'b0);
		wr(OFF_IRQ_MASK, 32'h4);
		chk(irq, 1'b1);
		rd(OFF_IRQ_MASK, 32'h4);
		rd(OFF_IRQ_STATUS, 32'h7);
		chk(irq, 1'b0);
		press <= 8'h00;
		cyc(4);
		wr(OFF_STATUS_CONTROL, 32'h7);
		rd(OFF_STATUS_CONTROL, 32'h03);
		wr(OFF_STATUS_CONTROL, 32'h2);
		stop_shallow <= 1'b1;
		press <= 8'h01;
		cyc(1);
		chk(wake, 1'b1);
		stop_shallow <= 1'b0;
		stop_deep <= 1'b1;
		cyc(2);
		stop_deep <= 1'b0;
		press <= 8'h00;
		cyc(1);
		rd(OFF_PIN_ENABLE, 32'h0);
		chk(kirq, 1'b0);
		res_en <= 8'h0F;
		cyc(1);
		chk({16'h0, pu, pd}, 32'h0F00);
		summarize();
	end
	initial
	begin
		#100000;
		err_total++;
		summarize();
	end
endmodule // keyboard_pin_interrupt_tb
